// ==== design/nrc_copro_glue.sv ====
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RULE_01 - External reset makes a system reset driving CPU and coprocessor.
// RULE_02 - Hot CPU reset from port 92h bit 0, EFh read, or pin.
// RULE_03 - The hot-reset pin starts the CPU reset without delay.
// RULE_04 - Port-triggered hot resets wait 6.72 us before the CPU reset.
// RULE_05 - A detected CPU shutdown cycle issues a CPU-only reset.
// RULE_06 - Each CPU-only reset is clock synchronous and 16 cycles long.
// RULE_07 - Writing F1h gives an 80-cycle coprocessor-only reset pulse.
// RULE_08 - Ready stays inactive 80 cycles after coprocessor reset falls; the code holds it only after F1h resets, not after system resets.
// RULE_09 - Misc settings bit 6 set blocks the F1h coprocessor reset.
// RULE_10 - Coprocessor error raises interrupt 13 and latches CPU busy.
// RULE_11 - Handler writes F0h; the device then clears the latched busy.
// RULE_12 - CPU busy always follows coprocessor busy as well.
// RULE_13 - Self-test via busy is requested only during system reset.
// RULE_14 - Hot CPU resets never request the self-test.
// RULE_15 - Operand request normally passes straight from coprocessor.
// RULE_16 - After an error, operand request is held once busy drops.
// RULE_17 - Writing F0h releases the held operand request.
// RULE_18 - Coprocessor cycles get ready after one wait state time-out.
// RULE_19 - External logic maps only even ports F8h-FEh to coprocessor.
// RULE_20 - Ports F0h and F1h are decoded on every address bit.
// RULE_21 - Misc settings bit 7 set stops EFh reads resetting the CPU.
// RULE_22 - Port 92h bit 0 stays set until rewritten or reset.
// RULE_23 - CPU reset sources are ORed; new requests never shorten a pulse.
// RULE_24 - System reset clears the error busy latch and operand hold.
module nrc_copro_glue (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // System and CPU reset sources
  input wire logic system_reset_drive_in,
  input wire logic supply_valid_in,
  input wire logic hot_reset_request_in,
  input wire logic cpu_shutdown_in,
  // Register port
  input wire logic [nrc_pkg::ADDR_W-1:0] io_addr_in,
  input wire logic [nrc_pkg::DATA_W-1:0] io_wdata_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  output logic [nrc_pkg::DATA_W-1:0] io_rdata_out,
  // Coprocessor side
  input wire logic copro_error_in,
  input wire logic copro_busy_in,
  input wire logic copro_operand_req_in,
  input wire logic copro_cycle_in,
  input wire logic cpu_ready_in,
  // CPU and coprocessor controls
  output logic cpu_reset_out,
  output logic copro_reset_out,
  output logic cpu_busy_out,
  output logic cpu_operand_req_out,
  output logic cpu_ready_out,
  output logic irq13_out
);

  nrc_pkg::nrc_io_req_t req;
  logic wr_port_a;
  logic rd_fast_rst;
  logic wr_busy_clr;
  logic wr_copro_rst;
  logic sys_rst_q;
  logic blk_rst;
  logic pa_rst_q;
  logic pa_a20_q;
  logic [7:0] misc_q;
  logic rc_q;
  logic rc_start;
  logic fast_req;
  logic dly_act;
  logic dly_done;
  logic cpu_start;
  logic cpu_act;
  logic cpu_rst_q;
  logic cp_start;
  logic cp_act;
  logic cp_done;
  logic cp_done_q;
  logic copro_rst_q;
  logic hold_act;
  logic ready_block;
  logic err_busy_q;
  logic pereq_hold_q;
  logic irq13_q;
  logic [1:0] ws_q;
  logic [7:0] rdata_q;
  logic [7:0] status_word;

  // Every address bit takes part, so F0h and F1h never alias here.
  function automatic logic io_hit(input nrc_pkg::nrc_io_req_t r,
                                  input logic [7:0] port);
    return r.addr == port; // [RULE_20]
  endfunction : io_hit

  assign req = {io_addr_in, io_wdata_in, io_wr_in, io_rd_in};
  assign wr_port_a = req.wr && io_hit(req, nrc_pkg::PORT_A_ADDR);
  assign rd_fast_rst = req.rd && io_hit(req, nrc_pkg::FAST_RST_ADDR);
  assign wr_busy_clr = req.wr && io_hit(req, nrc_pkg::BUSY_CLR_ADDR);
  assign wr_copro_rst = req.wr && io_hit(req, nrc_pkg::COPRO_RST_ADDR);

  // System reset from the external drive pin or a failing supply.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sys_rst_q <= 1'b1;
    end else begin
      sys_rst_q <= system_reset_drive_in || !supply_valid_in; // [RULE_01]
    end
  end

  assign blk_rst = rst_in || sys_rst_q;

  // Port 92h keeps its reset bit until rewritten or reset.
  always_ff @(posedge core_clk_in) begin
    if (blk_rst) begin
      pa_rst_q <= 1'b0;
      pa_a20_q <= 1'b0;
    end else if (wr_port_a) begin
      pa_rst_q <= req.wdata[nrc_pkg::PA_RST_BIT]; // [RULE_22]
      pa_a20_q <= req.wdata[nrc_pkg::PA_A20_BIT];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (blk_rst) begin
      misc_q <= nrc_pkg::MISC_RESET;
    end else if (req.wr && io_hit(req, nrc_pkg::MISC_ADDR)) begin
      misc_q <= req.wdata;
    end
  end

  // Edge of the hot-reset pin, so a held pin gives one pulse.
  always_ff @(posedge core_clk_in) begin
    if (blk_rst) begin
      rc_q <= 1'b0;
    end else begin
      rc_q <= hot_reset_request_in;
    end
  end

  assign rc_start = hot_reset_request_in && !rc_q; // [RULE_03]

  // Setting bit 0 (a 0 to 1 change) or reading EFh with misc bit 7 clear asks for a reset.
  assign fast_req =
    (wr_port_a && req.wdata[nrc_pkg::PA_RST_BIT] && !pa_rst_q) || // [RULE_02]
    (rd_fast_rst && !misc_q[nrc_pkg::MISC_NO_FAST_BIT]); // [RULE_21]

  nrc_pulse_timer u_hot_delay (
    .clk_in(core_clk_in),
    .rst_in(blk_rst),
    .start_in(fast_req),
    .len_in(nrc_pkg::HOT_DELAY_CYC), // [RULE_04]
    .active_out(dly_act),
    .done_out(dly_done)
  );

  assign cpu_start = rc_start || cpu_shutdown_in || dly_done; // [RULE_05] [RULE_23]

  nrc_pulse_timer u_cpu_reset (
    .clk_in(core_clk_in),
    .rst_in(blk_rst),
    .start_in(cpu_start),
    .len_in(nrc_pkg::CPU_RST_CYC), // [RULE_06]
    .active_out(cpu_act),
    .done_out()
  );

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cpu_rst_q <= 1'b1;
    end else begin
      cpu_rst_q <= sys_rst_q || cpu_act; // [RULE_01] [RULE_23]
    end
  end

  assign cp_start = wr_copro_rst && !misc_q[nrc_pkg::MISC_NO_CPRST_BIT]; // [RULE_09]

  nrc_pulse_timer u_copro_reset (
    .clk_in(core_clk_in),
    .rst_in(blk_rst),
    .start_in(cp_start),
    .len_in(nrc_pkg::COPRO_RST_CYC), // [RULE_07]
    .active_out(cp_act),
    .done_out(cp_done)
  );

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      copro_rst_q <= 1'b1;
      cp_done_q <= 1'b0;
    end else begin
      copro_rst_q <= sys_rst_q || cp_act; // [RULE_01] [RULE_07]
      cp_done_q <= cp_done;
    end
  end

  // The hold starts in the first cycle with the reset output low.
  nrc_pulse_timer u_ready_hold (
    .clk_in(core_clk_in),
    .rst_in(blk_rst),
    .start_in(cp_done_q),
    .len_in(nrc_pkg::READY_HOLD_CYC), // [RULE_08]
    .active_out(hold_act),
    .done_out()
  );

  // Error latch; an error in the clearing cycle wins over the clear.
  always_ff @(posedge core_clk_in) begin
    if (blk_rst) begin
      err_busy_q <= 1'b0; // [RULE_24]
    end else if (copro_error_in) begin
      err_busy_q <= 1'b1; // [RULE_10]
    end else if (wr_busy_clr) begin
      err_busy_q <= 1'b0; // [RULE_11]
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (blk_rst) begin
      pereq_hold_q <= 1'b0; // [RULE_24]
    end else if (wr_busy_clr) begin
      pereq_hold_q <= 1'b0; // [RULE_17]
    end else if (err_busy_q && !copro_busy_in) begin
      pereq_hold_q <= 1'b1; // [RULE_16]
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (blk_rst) begin
      irq13_q <= 1'b0;
    end else begin
      irq13_q <= copro_error_in; // [RULE_10]
    end
  end

  // Busy during system reset asks the CPU for its self-test; the
  // hot reset timer never feeds this term.
  assign cpu_busy_out = copro_busy_in || err_busy_q || sys_rst_q; // [RULE_12] [RULE_13] [RULE_14]
  assign cpu_operand_req_out = copro_operand_req_in || pereq_hold_q; // [RULE_15]
  assign cpu_reset_out = cpu_rst_q;
  assign copro_reset_out = copro_rst_q;
  assign irq13_out = irq13_q;

  // Wait-state counter; it saturates so an absent part cannot hang.
  always_ff @(posedge core_clk_in) begin
    if (blk_rst || !copro_cycle_in) begin
      ws_q <= nrc_pkg::WS_IDLE;
    end else if (ws_q != nrc_pkg::WAIT_STATE_CYC) begin
      ws_q <= ws_q + 1'b1; // [RULE_18]
    end
  end

  assign ready_block = cp_act || copro_rst_q || hold_act;
  assign cpu_ready_out = copro_cycle_in && !ready_block &&
    (cpu_ready_in || ws_q == nrc_pkg::WAIT_STATE_CYC); // [RULE_18] [RULE_08]

  assign status_word = {err_busy_q, pereq_hold_q, cpu_rst_q, copro_rst_q,
                        hold_act, dly_act, nrc_pkg::STATUS_PAD};

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rdata_q <= nrc_pkg::RDATA_IDLE;
    end else if (req.rd) begin
      case (req.addr)
        nrc_pkg::PORT_A_ADDR: begin
          rdata_q <= nrc_pkg::PORT_A_FILL |
            {6'h00, pa_a20_q, pa_rst_q};
        end
        nrc_pkg::FAST_RST_ADDR: begin
          rdata_q <= nrc_pkg::FAST_RST_READ;
        end
        nrc_pkg::MISC_ADDR: begin
          rdata_q <= misc_q;
        end
        nrc_pkg::STATUS_ADDR: begin
          rdata_q <= status_word;
        end
        default: begin
          rdata_q <= nrc_pkg::UNMAPPED_READ;
        end
      endcase
    end else begin
      rdata_q <= nrc_pkg::RDATA_IDLE;
    end
  end

  assign io_rdata_out = rdata_q;

  AST_SYS_RESET: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE_01]
    sys_rst_q |-> cpu_busy_out ##1 cpu_reset_out && copro_reset_out)
    else $error("System reset did not reach CPU and coprocessor.");

  AST_HOT_PIN: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE_03]
    rc_start && !blk_rst |=> cpu_act ##1 cpu_reset_out)
    else $error("Hot reset pin did not reset the CPU at once.");

  AST_HOT_DELAY: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE_04]
    fast_req && !dly_act && !blk_rst |=> dly_act && !dly_done
    ##167 dly_done)
    else $error("Port hot reset was not delayed.");

  AST_CPU_LEN: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE_06]
    $rose(cpu_act) && !sys_rst_q |-> cpu_act [*8] ##1 cpu_act [*8]
    ##1 !cpu_act || cpu_start)
    else $error("CPU reset pulse is not 16 cycles.");

  AST_COPRO_MASK: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE_09]
    wr_copro_rst && misc_q[nrc_pkg::MISC_NO_CPRST_BIT] && !cp_act
    |=> !cp_act)
    else $error("Coprocessor reset fired while disabled.");

  AST_READY_HOLD: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE_08]
    $fell(copro_reset_out) && $past(cp_done_q) && !blk_rst
    |-> hold_act [*8] ##0 !cpu_ready_out)
    else $error("Ready was not held after coprocessor reset.");

  AST_ERR_BUSY: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE_10]
    copro_error_in && !blk_rst |=> cpu_busy_out && irq13_out)
    else $error("Error did not latch busy and interrupt.");

  AST_BUSY_CLEAR: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE_11]
    wr_busy_clr && !copro_error_in |=> !err_busy_q ##0
    (cpu_busy_out == (copro_busy_in || sys_rst_q)))
    else $error("Busy clear port did not clear the latch.");

  AST_BUSY_PASS: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE_12]
    copro_busy_in |-> cpu_busy_out)
    else $error("CPU busy missed coprocessor busy.");

  AST_PEREQ_HOLD: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE_16]
    err_busy_q && !copro_busy_in && !wr_busy_clr && !blk_rst
    |=> cpu_operand_req_out)
    else $error("Operand request was not held after an error.");

  AST_PEREQ_PASS: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE_15]
    !pereq_hold_q |-> cpu_operand_req_out == copro_operand_req_in)
    else $error("Operand request does not follow the coprocessor.");

  AST_READY_TIMEOUT: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE_18]
    (copro_cycle_in && !ready_block && !blk_rst) [*3] |-> cpu_ready_out)
    else $error("Ready time-out did not fire.");

  AST_FAST_MASK: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE_21]
    rd_fast_rst && misc_q[nrc_pkg::MISC_NO_FAST_BIT] && !dly_act
    && !wr_port_a |=> !dly_act)
    else $error("Masked fast reset read started a reset.");

endmodule : nrc_copro_glue

`default_nettype wire

// ==== design/nrc_pkg.sv ====
package nrc_pkg;

  // I/O space and data widths.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CNT_W = 8;

  // Fully decoded I/O ports.
  localparam logic [7:0] PORT_A_ADDR = 8'h92;
  localparam logic [7:0] FAST_RST_ADDR = 8'hEF;
  localparam logic [7:0] BUSY_CLR_ADDR = 8'hF0;
  localparam logic [7:0] COPRO_RST_ADDR = 8'hF1;
  localparam logic [7:0] MISC_ADDR = 8'hE0;
  localparam logic [7:0] STATUS_ADDR = 8'hE1;

  // Field positions.
  localparam int PA_RST_BIT = 0;
  localparam int PA_A20_BIT = 1;
  localparam int MISC_NO_CPRST_BIT = 6;
  localparam int MISC_NO_FAST_BIT = 7;

  // Reset and read-back values.
  localparam logic [7:0] MISC_RESET = 8'h00;
  localparam logic [7:0] PORT_A_FILL = 8'hFC;
  localparam logic [7:0] FAST_RST_READ = 8'hFF;
  localparam logic [7:0] UNMAPPED_READ = 8'hFF;
  localparam logic [7:0] RDATA_IDLE = 8'h00;
  localparam logic [1:0] STATUS_PAD = 2'h0;

  // Timing, in cycles of the double-rate clock at 25 MHz.
  localparam int CLK_PERIOD_NS = 40;
  localparam int HOT_DELAY_NS = 6720;
  localparam int HOT_DELAY_CYC_I =
    (HOT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] HOT_DELAY_CYC = 8'(HOT_DELAY_CYC_I);
  localparam logic [7:0] CPU_RST_CYC = 8'h10;
  localparam logic [7:0] COPRO_RST_CYC = 8'h50;
  localparam logic [7:0] READY_HOLD_CYC = 8'h50;
  localparam logic [7:0] CNT_IDLE = 8'h00;
  localparam logic [7:0] CNT_LAST = 8'h01;
  localparam logic [1:0] WAIT_STATE_CYC = 2'h2;
  localparam logic [1:0] WS_IDLE = 2'h0;

  // One I/O access as seen on the register port.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } nrc_io_req_t;

endpackage : nrc_pkg

// ==== design/nrc_pulse_timer.sv ====
`timescale 1ns/1ps
`default_nettype none

module nrc_pulse_timer (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control
  input wire logic start_in,
  input wire logic [nrc_pkg::CNT_W-1:0] len_in,
  // Status
  output logic active_out,
  output logic done_out
);

  logic [nrc_pkg::CNT_W-1:0] cnt_q;

  // A start while running is ignored, so a pulse is never cut short.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_q <= nrc_pkg::CNT_IDLE;
    end else if (start_in && cnt_q == nrc_pkg::CNT_IDLE) begin
      cnt_q <= len_in;
    end else if (cnt_q != nrc_pkg::CNT_IDLE) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign active_out = (cnt_q != nrc_pkg::CNT_IDLE);
  assign done_out = (cnt_q == nrc_pkg::CNT_LAST);

  AST_TMR_LOAD: assert property (@(posedge clk_in) disable iff (rst_in)
    start_in && !active_out |=> cnt_q == $past(len_in)) // [RULE_06]
    else $error("Timer did not load its length.");

  AST_TMR_NO_SHORTEN: assert property (@(posedge clk_in)
    disable iff (rst_in)
    active_out && !done_out |=> active_out) // [RULE_23]
    else $error("Running pulse was shortened.");

endmodule : nrc_pulse_timer

`default_nettype wire

// ==== dv/nrc_copro_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module nrc_copro_model (
  // Clock and controls from the glue
  input wire logic clk_in,
  input wire logic copro_reset_in,
  input wire logic copro_cycle_in,
  // Coprocessor pins
  output logic copro_error_out,
  output logic copro_busy_out,
  output logic copro_operand_req_out,
  output logic ready_out
);
  int lat = 0;
  int cnt = 0;

  initial begin
    copro_error_out = 1'b0;
    copro_busy_out = 1'b0;
    copro_operand_req_out = 1'b0;
    ready_out = 1'b0;
  end

  // A latency of zero stands for an absent coprocessor that never answers.
  // Only even coprocessor ports are steered here by the host decode.
  always @(posedge clk_in) begin
    cnt <= copro_cycle_in ? cnt + 1 : 0;
    ready_out <= copro_cycle_in && lat != 0 && cnt + 1 >= lat;
    if (copro_reset_in) begin
      copro_error_out <= 1'b0;
      copro_busy_out <= 1'b0;
    end
  end

  task automatic set_pins(input logic e, input logic b, input logic r);
    @(posedge clk_in);
    copro_error_out <= e;
    copro_busy_out <= b;
    copro_operand_req_out <= r;
  endtask : set_pins
endmodule : nrc_copro_model

`default_nettype wire

// ==== dv/nrc_copro_glue_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module nrc_copro_glue_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sys_drv = 1'b0;
  logic supply = 1'b1;
  logic hot = 1'b0;
  logic shut = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic cyc = 1'b0;
  logic [7:0] d;
  wire logic [7:0] rdata;
  wire logic err, busy, req, rdy_in, cpu_rst, cp_rst;
  wire logic cpu_busy, cpu_req, rdy, irq;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int w, n;

  nrc_copro_glue dut_u (.core_clk_in(clk), .rst_in(rst),
    .system_reset_drive_in(sys_drv), .supply_valid_in(supply),
    .hot_reset_request_in(hot), .cpu_shutdown_in(shut),
    .io_addr_in(addr), .io_wdata_in(wdata), .io_wr_in(wr),
    .io_rd_in(rd), .io_rdata_out(rdata), .copro_error_in(err),
    .copro_busy_in(busy), .copro_operand_req_in(req),
    .copro_cycle_in(cyc), .cpu_ready_in(rdy_in),
    .cpu_reset_out(cpu_rst), .copro_reset_out(cp_rst),
    .cpu_busy_out(cpu_busy), .cpu_operand_req_out(cpu_req),
    .cpu_ready_out(rdy), .irq13_out(irq));

  nrc_copro_model model_u (.clk_in(clk), .copro_reset_in(cp_rst),
    .copro_cycle_in(cyc), .copro_error_out(err), .copro_busy_out(busy),
    .copro_operand_req_out(req), .ready_out(rdy_in));

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic close_out;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  // The ceiling sits far above the roughly 1900 cycles the run needs.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic chk(input string name, input logic [7:0] e,
                     input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  task automatic rng(input string name, input int v, input int lo,
                     input int hi);
    comparisons++;
    if (v < lo || v > hi) begin
      n_errors++;
      $display("ERROR %s expected %0d..%0d seen %0d", name, lo, hi, v);
    end
  endtask : rng

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  task automatic io_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : io_wr

  task automatic io_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : io_rd

  function automatic logic sig(input int sel);
    case (sel)
      0: return cpu_rst;
      1: return cp_rst;
      default: return rdy;
    endcase
  endfunction : sig

  // Counts cycles until the output rises, then how long it stays high.
  task automatic meas(input int sel, input int lim, output int wt,
                      output int wd);
    wt = 0;
    wd = 0;
    while (sig(sel) !== 1'b1 && wt < lim) begin
      @(posedge clk);
      #1;
      wt++;
    end
    while (sig(sel) === 1'b1 && wd < 300) begin
      @(posedge clk);
      #1;
      wd++;
    end
  endtask : meas

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    tick(4);
    chk("cpu_reset", 8'h00, {7'h00, cpu_rst});
    io_rd(8'h92, d);
    chk("port_a", 8'hFC, d);
    io_rd(8'h55, d);
    chk("unmapped", 8'hFF, d);
    io_wr(8'h92, 8'h01);
    meas(0, 300, w, n);
    rng("port_delay", w, 168, 172);
    chk("port_width", 8'h10, 8'(n));
    io_rd(8'h92, d);
    chk("port_a_held", 8'hFD, d);
    io_wr(8'h92, 8'h00);
    @(posedge clk);
    hot <= 1'b1;
    meas(0, 10, w, n);
    rng("pin_delay", w, 1, 3);
    chk("pin_width", 8'h10, 8'(n));
    @(posedge clk);
    hot <= 1'b0;
    shut <= 1'b1;
    @(posedge clk);
    shut <= 1'b0;
    tick(4);
    chk("shutdown_reset", 8'h01, {7'h00, cpu_rst});
    chk("hot_busy", 8'h00, {7'h00, cpu_busy});
    meas(0, 5, w, n);
    io_rd(8'hEF, d);
    chk("fast_read", 8'hFF, d);
    meas(0, 300, w, n);
    rng("fast_delay", w, 168, 172);
    io_wr(8'hE0, 8'h80);
    io_rd(8'hEF, d);
    meas(0, 250, w, n);
    chk("fast_off", 8'h00, 8'(n));
    io_wr(8'hE0, 8'h40);
    io_rd(8'hE0, d);
    chk("misc", 8'h40, d);
    io_wr(8'hF1, 8'h00);
    meas(1, 20, w, n);
    chk("copro_off", 8'h00, 8'(n));
    io_wr(8'hE0, 8'h00);
    io_wr(8'h71, 8'h00);
    meas(1, 20, w, n);
    chk("decode_f1", 8'h00, 8'(n));
    io_wr(8'hF1, 8'h00);
    meas(1, 10, w, n);
    chk("copro_width", 8'h50, 8'(n));
    @(posedge clk);
    cyc <= 1'b1;
    meas(2, 120, w, n);
    rng("ready_hold", w, 76, 84);
    @(posedge clk);
    cyc <= 1'b0;
    tick(2);
    @(posedge clk);
    cyc <= 1'b1;
    meas(2, 10, w, n);
    rng("ready_timeout", w, 2, 3);
    @(posedge clk);
    cyc <= 1'b0;
    model_u.lat = 1;
    tick(2);
    @(posedge clk);
    cyc <= 1'b1;
    meas(2, 10, w, n);
    rng("ready_answer", w, 1, 1);
    @(posedge clk);
    cyc <= 1'b0;
    model_u.set_pins(1'b0, 1'b1, 1'b0);
    tick(1);
    chk("busy_follow", 8'h01, {7'h00, cpu_busy});
    model_u.set_pins(1'b1, 1'b1, 1'b0);
    tick(2);
    chk("irq13", 8'h01, {7'h00, irq});
    chk("req_busy", 8'h00, {7'h00, cpu_req});
    model_u.set_pins(1'b0, 1'b0, 1'b0);
    tick(2);
    chk("busy_latch", 8'h01, {7'h00, cpu_busy});
    chk("req_hold", 8'h01, {7'h00, cpu_req});
    io_rd(8'hE1, d);
    chk("status", 8'hC0, d);
    io_wr(8'h70, 8'h00);
    tick(1);
    chk("decode_f0", 8'h01, {7'h00, cpu_busy});
    io_wr(8'hF0, 8'h00);
    tick(1);
    chk("busy_clear", 8'h00, {7'h00, cpu_busy});
    chk("req_free", 8'h00, {7'h00, cpu_req});
    model_u.set_pins(1'b1, 1'b0, 1'b1);
    tick(1);
    chk("req_pass", 8'h01, {7'h00, cpu_req});
    model_u.set_pins(1'b0, 1'b0, 1'b0);
    @(posedge clk);
    supply <= 1'b0;
    tick(3);
    chk("supply_reset", 8'h01, {7'h00, cpu_rst});
    @(posedge clk);
    supply <= 1'b1;
    sys_drv <= 1'b1;
    tick(3);
    chk("sys_copro", 8'h01, {7'h00, cp_rst});
    chk("self_test", 8'h01, {7'h00, cpu_busy});
    @(posedge clk);
    sys_drv <= 1'b0;
    tick(4);
    chk("busy_reset", 8'h00, {7'h00, cpu_busy});
    chk("req_reset", 8'h00, {7'h00, cpu_req});
    close_out();
  end
endmodule : nrc_copro_glue_tb

`default_nettype wire
